// [hw/audio_status_regs.vh]
/*
  Offsets, field positions and reset values of the audio control,
  self-test return error and pin level status registers.
  Assumes inclusion by the register bank module only.
*/
`ifndef AUDIO_STATUS_REGS_VH
`define AUDIO_STATUS_REGS_VH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define AUDIO_DATAPATH_CONTROL_ADDR  8'h1a
`define BACKCHANNEL_CRC_ERR_ADDR     8'h1b
`define PIN_LEVEL_STATUS_LOW_ADDR    8'h1c
`define PIN_LEVEL_STATUS_HIGH_ADDR   8'h1d

// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define BLOCK_REPEATER_MODE_BIT      7
`define AUX_AUDIO_MIRROR_BIT         3
`define SURROUND_ENABLE_BIT          0
`define SHARED_PIN_MSB               7
`define SHARED_PIN_LSB               5
`define LOCAL_PIN_MSB                3
`define LOCAL_PIN_LSB                0
`define PIN8_LEVEL_BIT               0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define BLOCK_REPEATER_MODE_RST      1'h0
`define SURROUND_ENABLE_RST          1'h1
`define AUTO_DETECT_RST              1'h0
`define RDATA_RST                    8'h00
`define RVALID_RST                   1'h0
`define COUNT_RST                    8'h00
`define COUNT_MAX                    8'hff

`endif

// [hw/audio_status_bank.v]
/*
  Register bank: audio datapath control (0x1a), per-port self-test
  return CRC error count (0x1b) and pin level status (0x1c, 0x1d).
  Assumes a register access engine in front that gives one-cycle write
  and read strobes with an 8-bit offset, and that the port select
  bit, pin levels, error events and clear events are synchronous.
*/
// Contract
// - Bit7 set blocks repeater automatic mode detection
// - Bit0 surround enable, resets to one
// - Surround forces data-island transport only
// - Repeater in-band detection may override surround
// - Bit3 mirrors auxiliary audio enable, read only
// - Error count read only, clears on events
// - Count per port; select picks port 1
// - Port select routes port-specific register access
// - Bits 7-5 live shared pins, zero if second
// - Bits 3-0 local, remote if second selected
// - High status bit0 shows pin 8 level
`timescale 1ns/100ps
`include "audio_status_regs.vh"

module audio_status_bank #(
  parameter PORTS = 2
) (
  input  wire       core_clk_i,
  input  wire       rst_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       second_port_select_i,
  input  wire       repeater_mode_i,
  input  wire       inband_mode_valid_i,
  input  wire       inband_surround_i,
  input  wire       aux_audio_enable_i,
  input  wire [1:0] crc_error_i,
  input  wire [1:0] link_lost_i,
  input  wire [1:0] selftest_restart_i,
  input  wire [1:0] crc_error_reset_i,
  input  wire       pin7_level_i,
  input  wire       pin6_level_i,
  input  wire       pin5_level_i,
  input  wire [3:0] pin_low_level_i,
  input  wire [3:0] remote_pin_level_i,
  input  wire       pin8_level_i,
  output reg  [7:0] reg_rdata_o,
  output reg        reg_rvalid_o,
  output reg        surround_active_o,
  output reg        data_island_only_o,
  output reg        auto_mode_detect_o
);

  // ----------------------------------------------------------------
  // Control state and decode
  // ----------------------------------------------------------------
  reg                block_repeater_ff;
  reg                surround_ff;
  reg                nxt_block_repeater;
  reg                nxt_surround;
  reg                hit_ctl;
  reg                hit_cnt;
  reg                hit_sts_low;
  reg                hit_sts_high;
  reg                ctl_wr;

  // ----------------------------------------------------------------
  // Mode and read path signals
  // ----------------------------------------------------------------
  reg                detect_allowed;
  reg                inband_override;
  reg                nxt_surround_active;
  reg                nxt_island_only;
  reg                nxt_auto_mode_detect;
  // Counts flattened so that every slice has one driver
  wire [8*PORTS-1:0] err_cnt_all;
  wire [2:0]         shared_pin_live;
  wire [2:0]         shared_pin_rd;
  wire [3:0]         low_pin_rd;
  reg  [7:0]         ctl_rd;
  reg  [7:0]         cnt_rd;
  reg  [7:0]         sts_low_rd;
  reg  [7:0]         sts_high_rd;
  reg  [7:0]         nxt_rdata;
  reg                nxt_rvalid;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always @* begin
    hit_ctl      = (reg_addr_i == `AUDIO_DATAPATH_CONTROL_ADDR);
    hit_cnt      = (reg_addr_i == `BACKCHANNEL_CRC_ERR_ADDR);
    hit_sts_low  = (reg_addr_i == `PIN_LEVEL_STATUS_LOW_ADDR);
    hit_sts_high = (reg_addr_i == `PIN_LEVEL_STATUS_HIGH_ADDR);
  end

  // ----------------------------------------------------------------
  // Control register write
  // ----------------------------------------------------------------
  // Writes to status or unmapped offsets fall away
  always @* begin
    ctl_wr = reg_wr_i && hit_ctl;
  end

  // Only bits 7 and 0 are writable; the rest are dropped
  always @* begin
    nxt_block_repeater = block_repeater_ff;
    nxt_surround       = surround_ff;
    if (ctl_wr) begin
      nxt_block_repeater = reg_wdata_i[`BLOCK_REPEATER_MODE_BIT];
      nxt_surround       = reg_wdata_i[`SURROUND_ENABLE_BIT];
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      block_repeater_ff <= `BLOCK_REPEATER_MODE_RST;
      surround_ff       <= `SURROUND_ENABLE_RST;
    end else begin
      block_repeater_ff <= nxt_block_repeater;
      surround_ff       <= nxt_surround;
    end
  end

  // ----------------------------------------------------------------
  // Effective audio mode
  // ----------------------------------------------------------------
  // Detection only acts in a repeater and only when not blocked
  always @* begin
    detect_allowed = repeater_mode_i && !block_repeater_ff;
  end

  // Stored bit stands unless detection is allowed and valid in-band information is present
  always @* begin
    inband_override = detect_allowed && inband_mode_valid_i;
  end

  always @* begin
    nxt_surround_active = surround_ff;
    if (inband_override) begin
      nxt_surround_active = inband_surround_i;
    end
  end

  // Surround has no transport but the data-island one
  always @* begin
    nxt_island_only      = nxt_surround_active;
    nxt_auto_mode_detect = detect_allowed;
  end

  // ----------------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------------
  // Registered: one cycle late, but free of decode glitches
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      surround_active_o <= `SURROUND_ENABLE_RST;
    end else begin
      surround_active_o <= nxt_surround_active;
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      data_island_only_o <= `SURROUND_ENABLE_RST;
    end else begin
      data_island_only_o <= nxt_island_only;
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      auto_mode_detect_o <= `AUTO_DETECT_RST;
    end else begin
      auto_mode_detect_o <= nxt_auto_mode_detect;
    end
  end

  // ----------------------------------------------------------------
  // Per-port error counters
  // ----------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < PORTS; p = p + 1) begin : g_port
      reg  [7:0] cnt_ff;
      reg  [7:0] nxt_cnt;
      wire       clr;
      wire       sat;
      wire       inc;

      // Any of the three clear sources empties the count
      assign clr = link_lost_i[p] || selftest_restart_i[p] ||
                   crc_error_reset_i[p];
      // Saturate at the top rather than wrap to a small value
      assign sat = (cnt_ff == `COUNT_MAX);
      assign inc = crc_error_i[p] && !sat;

      // Clear wins over a same-cycle error
      always @* begin
        nxt_cnt = cnt_ff;
        if (clr) begin
          nxt_cnt = `COUNT_RST;
        end else if (inc) begin
          nxt_cnt = cnt_ff + 8'h01;
        end
      end

      always @(posedge core_clk_i) begin
        if (rst_i) begin
          cnt_ff <= `COUNT_RST;
        end else begin
          cnt_ff <= nxt_cnt;
        end
      end

      // No write path reaches the count; it is read only
      assign err_cnt_all[8*p +: 8] = cnt_ff;
    end
  endgenerate

  // ----------------------------------------------------------------
  // Port routing of the count
  // ----------------------------------------------------------------
  // Port 1 copy while the select is set, port 0 copy otherwise
  always @* begin
    if (second_port_select_i) begin
      cnt_rd = err_cnt_all[15:8];
    end else begin
      cnt_rd = err_cnt_all[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Pin level status
  // ----------------------------------------------------------------
  // Levels are live at the read edge, never latched
  assign shared_pin_live = {pin7_level_i, pin6_level_i, pin5_level_i};

  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_low_pin
      // The remote level stands in for the local one in the port 1 view
      assign low_pin_rd[b] = second_port_select_i ?
                             remote_pin_level_i[b] :
                             pin_low_level_i[b];
    end
    for (b = 0; b < 3; b = b + 1) begin : g_shared_pin
      // Shared pins have no port 1 copy, so that view reads zero
      assign shared_pin_rd[b] = !second_port_select_i &&
                                shared_pin_live[b];
    end
  endgenerate

  always @* begin
    sts_low_rd = 8'h00;
    sts_low_rd[`SHARED_PIN_MSB:`SHARED_PIN_LSB] = shared_pin_rd;
    sts_low_rd[`LOCAL_PIN_MSB:`LOCAL_PIN_LSB]   = low_pin_rd;
  end

  always @* begin
    sts_high_rd = 8'h00;
    sts_high_rd[`PIN8_LEVEL_BIT] = pin8_level_i;
  end

  // ----------------------------------------------------------------
  // Control register read
  // ----------------------------------------------------------------
  always @* begin
    ctl_rd = 8'h00;
    ctl_rd[`BLOCK_REPEATER_MODE_BIT] = block_repeater_ff;
    ctl_rd[`AUX_AUDIO_MIRROR_BIT]    = aux_audio_enable_i;
    ctl_rd[`SURROUND_ENABLE_BIT]     = surround_ff;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped offsets select nothing and read as zero
  always @* begin
    nxt_rdata  = ({8{hit_ctl}}      & ctl_rd)     |
                 ({8{hit_cnt}}      & cnt_rd)     |
                 ({8{hit_sts_low}}  & sts_low_rd) |
                 ({8{hit_sts_high}} & sts_high_rd);
    nxt_rvalid = reg_rd_i;
  end

  // Read data holds until the next read strobe
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= `RDATA_RST;
    end else if (reg_rd_i) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      reg_rvalid_o <= `RVALID_RST;
    end else begin
      reg_rvalid_o <= nxt_rvalid;
    end
  end

endmodule // audio_status_bank

// [verif/audio_status_bank_props.sv]
/* Port checker for the audio status bank.
   Assumes binding to it; reset is synchronous, active high. */
`timescale 1ns/100ps
// --------
// Checker
// --------
module audio_status_bank_props (
  input wire       core_clk_i, rst_i, reg_rd_i, second_port_select_i,
  input wire       aux_audio_enable_i, pin7_level_i, pin6_level_i,
  input wire       pin5_level_i, pin8_level_i, reg_rvalid_o,
  input wire       surround_active_o, data_island_only_o,
  input wire [1:0] link_lost_i,
  input wire [3:0] pin_low_level_i, remote_pin_level_i,
  input wire [7:0] reg_addr_i, reg_rdata_o
);
  wire rd_c = reg_rd_i && reg_addr_i == 8'h1c;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  property p_rv; reg_rvalid_o == $past(reg_rd_i); endproperty
  a_rv: assert property (p_rv) else $error("bad rvalid");
  property p_lo; rd_c && !second_port_select_i |=> reg_rdata_o == $past(
    {pin7_level_i, pin6_level_i, pin5_level_i, 1'h0, pin_low_level_i});
  endproperty
  a_lo: assert property (p_lo) else $error("bad local");
  property p_rm; rd_c && second_port_select_i |=>
    reg_rdata_o == {4'h0, $past(remote_pin_level_i)}; endproperty
  a_rm: assert property (p_rm) else $error("bad remote");
  property p_hi; reg_rd_i && reg_addr_i == 8'h1d |=>
    reg_rdata_o == {7'h0, $past(pin8_level_i)}; endproperty
  a_hi: assert property (p_hi) else $error("bad pin8");
  property p_ax; reg_rd_i && reg_addr_i == 8'h1a |=>
    reg_rdata_o[3] == $past(aux_audio_enable_i); endproperty
  a_ax: assert property (p_ax) else $error("bad mirror");
  property p_cl; link_lost_i == 2'h3 ##2 (reg_rd_i && reg_addr_i == 8'h1b)
    |=> reg_rdata_o == 8'h00; endproperty
  a_cl: assert property (p_cl) else $error("no clear");
  property p_di; data_island_only_o == surround_active_o; endproperty
  a_di: assert property (p_di) else $error("bad island");
  property p_un; reg_rd_i && (reg_addr_i < 8'h1a || reg_addr_i > 8'h1d)
    |=> reg_rdata_o == 8'h00; endproperty
  a_un: assert property (p_un) else $error("bad unmapped");
endmodule // audio_status_bank_props
bind audio_status_bank audio_status_bank_props u_props (.*);

// [verif/audio_status_bank_tb.sv]
/* Bench for the audio status bank.
   Assumes the bank header is on the include path. */
`timescale 1ns/100ps
// --------
// Bench
// --------
module audio_status_bank_tb;
  reg        core_clk_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  reg  [7:0] reg_addr_i = 8'h0, reg_wdata_i = 8'h0;
  reg        second_port_select_i = 0, repeater_mode_i = 0;
  reg        inband_mode_valid_i = 0, inband_surround_i = 0;
  reg        aux_audio_enable_i = 0, pin8_level_i = 0;
  reg        pin7_level_i = 0, pin6_level_i = 0, pin5_level_i = 0;
  reg  [1:0] crc_error_i = 0, link_lost_i = 0;
  reg  [1:0] selftest_restart_i = 0, crc_error_reset_i = 0;
  reg  [3:0] pin_low_level_i = 0, remote_pin_level_i = 0;
  wire [7:0] reg_rdata_o;
  wire       reg_rvalid_o, surround_active_o;
  wire       data_island_only_o, auto_mode_detect_o;
  integer    err_count = 0, checks = 0, cyc = 0, i;
  audio_status_bank DUT (.*);
  always #4 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      err_count = err_count + 1;
      wrap_up;
    end
  end
  task chk(input [7:0] s, x, input [47:0] n);
    checks = checks + 1;
    if (s !== x) begin
      err_count = err_count + 1;
      $display("unexpected %0s exp %h seen %h", n, x, s);
    end
  endtask
  // Idle cycle after each strobe so no signal is set twice in a step
  task wr(input [7:0] a, d);
    {reg_wr_i, reg_addr_i, reg_wdata_i} = {1'h1, a, d};
    @(negedge core_clk_i);
    reg_wr_i = 0;
    @(negedge core_clk_i);
  endtask
  task rd(input [7:0] a, x);
    {reg_rd_i, reg_addr_i} = {1'h1, a};
    @(negedge core_clk_i);
    reg_rd_i = 0;
    chk(reg_rvalid_o, 8'h1, "rvalid");
    chk(reg_rdata_o, x, "rdata");
    @(negedge core_clk_i);
  endtask
  task ev(input [7:0] v);
    {crc_error_i, link_lost_i, selftest_restart_i, crc_error_reset_i} = v;
    @(negedge core_clk_i);
    {crc_error_i, link_lost_i, selftest_restart_i, crc_error_reset_i} = 0;
    @(negedge core_clk_i);
  endtask
  task t_ctl;
    chk(surround_active_o, 8'h1, "sur");
    chk(data_island_only_o, 8'h1, "isl");
    chk(auto_mode_detect_o, 8'h0, "auto");
    rd(8'h1a, 8'h01);
    aux_audio_enable_i = 1;
    wr(8'h1a, 8'hff);
    rd(8'h1a, 8'h89);
    {repeater_mode_i, inband_mode_valid_i} = 2'h3;
    repeat (2) @(negedge core_clk_i);
    chk(auto_mode_detect_o, 8'h0, "auto");
    chk(surround_active_o, 8'h1, "sur");
    wr(8'h1a, 8'h01);
    chk(auto_mode_detect_o, 8'h1, "auto");
    chk(surround_active_o, 8'h0, "sur");
    inband_surround_i = 1;
    repeat (2) @(negedge core_clk_i);
    chk(data_island_only_o, 8'h1, "isl");
    chk(surround_active_o, 8'h1, "sur");
    repeater_mode_i = 0;
    wr(8'h1a, 8'h00);
    chk(surround_active_o, 8'h0, "sur");
    chk(data_island_only_o, 8'h0, "isl");
    chk(auto_mode_detect_o, 8'h0, "auto");
    $display("t_ctl end");
  endtask
  task t_cnt;
    for (i = 0; i < 3; i = i + 1) begin
      repeat (i + 1) ev(8'hc0);
      ev(8'h80);
      wr(8'h1b, 8'hff);
      second_port_select_i = 0;
      rd(8'h1b, 8'h1 + i[7:0]);
      second_port_select_i = 1;
      rd(8'h1b, 8'h2 + i[7:0]);
      ev(8'h30 >> (2 * i)); // Each clear source in turn
      rd(8'h1b, 8'h00);
      second_port_select_i = 0;
      rd(8'h1b, 8'h00);
    end
    ev(8'hc3); // Errors and clears together; the clear wins
    rd(8'h1b, 8'h00);
    $display("t_cnt end");
  endtask
  task t_pins;
    for (i = 0; i < 2; i = i + 1) begin
      {pin7_level_i, pin6_level_i, pin5_level_i, pin8_level_i} =
        i ? 4'hb : 4'h4;
      pin_low_level_i = i ? 4'ha : 4'h5;
      remote_pin_level_i = ~pin_low_level_i;
      second_port_select_i = 0;
      rd(8'h1c, i ? 8'haa : 8'h45);
      rd(8'h1d, i ? 8'h01 : 8'h00);
      second_port_select_i = 1;
      rd(8'h1c, i ? 8'h05 : 8'h0a);
      rd(8'h1f, 8'h00);
    end
    $display("t_pins end");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge core_clk_i);
    rst_i = 0;
    t_ctl;
    t_cnt;
    t_pins;
    wrap_up;
  end
endmodule // audio_status_bank_tb
